// *** hw/dwpc_top.sv ***
/*
 * Command interpreter for output format, window placement, single picture
 * stepping and reduced rate playback.
 * Assumes the decode engine reports finished pictures with a one-cycle pulse
 * and that sync pins are asynchronous to clk_in.
 */
`timescale 1ns/10ps
`default_nettype none
module dwpc_top
    import dwpc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Register port
    input  wire logic [3:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    // Display timing pins
    input  wire logic        vsync_n_in,
    // Decode engine side
    input  wire logic        pic_done_in,
    input  wire logic        seq_hdr_in,
    input  wire logic [14:0] seq_hsize_in,
    input  wire logic [14:0] seq_vsize_in,
    input  wire logic        av_sync_go_in,
    output logic             decode_go_out,
    output logic             post_pic_out,
    output logic             unblank_out,
    output logic             av_sync_en_out,
    // Display side
    output logic             field_60hz_out,
    output logic      [14:0] win_x_out,
    output logic      [14:0] win_y_out,
    output logic      [14:0] win_w_out,
    output logic      [14:0] win_h_out,
    output logic      [3:0]  speed_out,
    output logic      [2:0]  state_out
);

    ////////////////////////////////////////////////////////////////////
    // Host command memory and execute strobe
    logic [15:0] cmd_ff;
    logic [15:0] arg_ff [1:4];
    logic        exec;

    // Words only stored here; nothing acts until execute
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_ff    <= 16'h0000;
            arg_ff[1] <= 16'h0000;
            arg_ff[2] <= 16'h0000;
            arg_ff[3] <= 16'h0000;
            arg_ff[4] <= 16'h0000;
        end else if (wr_in) begin
            if (addr_in == REG_CMD)
                cmd_ff <= wdata_in;
            if (addr_in >= REG_ARG1 && addr_in <= REG_ARG4)
                arg_ff[addr_in[2:0]] <= wdata_in;
        end
    end

    assign exec = wr_in && addr_in == REG_EXEC;

    // Command decode, valid only in the execute cycle
    logic is_fmt, is_win, is_step, is_slow;
    assign is_fmt  = exec && cmd_ff == CMD_FORMAT;
    assign is_win  = exec && cmd_ff == CMD_WINDOW;
    assign is_step = exec && cmd_ff == CMD_STEP;
    assign is_slow = exec && cmd_ff == CMD_SLOW;

    ////////////////////////////////////////////////////////////////////
    // Field sync synchroniser and active (falling) edge
    logic vs_meta_ff, vs_sync_ff, vs_prev_ff, vs_edge;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            vs_meta_ff <= 1'b1;
            vs_sync_ff <= 1'b1;
            vs_prev_ff <= 1'b1;
        end else begin
            vs_meta_ff <= vsync_n_in;
            vs_sync_ff <= vs_meta_ff;
            vs_prev_ff <= vs_sync_ff;
        end
    end
    // Idle-high reset values, so no false edge right after reset
    assign vs_edge = vs_prev_ff && !vs_sync_ff;

    ////////////////////////////////////////////////////////////////////
    // Output format: field rate switches on execution
    logic fmt60_ff;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            fmt60_ff <= 1'b1;
        else if (is_fmt && arg_ff[1][2:0] == FMT_60HZ)
            fmt60_ff <= 1'b1;
        else if (is_fmt && arg_ff[1][2:0] == FMT_50HZ)
            fmt60_ff <= 1'b0;
    end
    assign field_60hz_out = fmt60_ff;

    ////////////////////////////////////////////////////////////////////
    // Window: staged arguments, applied at next field sync
    logic [14:0] pend_x_ff, pend_y_ff, pend_w_ff, pend_h_ff;
    logic        pend_auto_w_ff, pend_auto_h_ff, pend_ff;
    logic        auto_w_ff, auto_h_ff;
    logic [14:0] act_x_ff, act_y_ff, act_w_ff, act_h_ff;

    // Zero size selects the sequence size; width in display pixels is
    // twice the source width since each source pixel is doubled
    function automatic logic [14:0] full_w(input logic [14:0] hs);
        full_w = {hs[13:0], 1'b0};
    endfunction

    // Bit 15 of each word is ignored; only bits 14:0 are kept
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pend_x_ff      <= WIN_ARG_RST;
            pend_y_ff      <= WIN_ARG_RST;
            pend_w_ff      <= WIN_ARG_RST;
            pend_h_ff      <= WIN_ARG_RST;
            pend_auto_w_ff <= 1'b1;
            pend_auto_h_ff <= 1'b1;
        end else if (is_win) begin
            pend_x_ff      <= arg_ff[1][14:0];
            pend_y_ff      <= arg_ff[2][14:0];
            pend_w_ff      <= arg_ff[3][14:0];
            pend_h_ff      <= arg_ff[4][14:0];
            pend_auto_w_ff <= arg_ff[3][14:0] == 15'h0000;
            pend_auto_h_ff <= arg_ff[4][14:0] == 15'h0000;
        end
    end

    // Pending flag: a new execution in the edge cycle stays pending
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            pend_ff <= 1'b0;
        else if (is_win)
            pend_ff <= 1'b1;
        else if (vs_edge)
            pend_ff <= 1'b0;
    end

    // Active window; auto sizes only refresh on window or sequence header,
    // never on a format change alone
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            act_x_ff  <= WIN_ARG_RST;
            act_y_ff  <= WIN_ARG_RST;
            act_w_ff  <= WIN_ARG_RST;
            act_h_ff  <= WIN_ARG_RST;
            auto_w_ff <= 1'b1;
            auto_h_ff <= 1'b1;
        end else if (pend_ff && vs_edge) begin
            act_x_ff  <= pend_x_ff;
            act_y_ff  <= pend_y_ff;
            auto_w_ff <= pend_auto_w_ff;
            auto_h_ff <= pend_auto_h_ff;
            act_w_ff  <= pend_auto_w_ff ? full_w(seq_hsize_in)
                                        : pend_w_ff;
            act_h_ff  <= pend_auto_h_ff ? seq_vsize_in
                                        : pend_h_ff;
        end else if (seq_hdr_in) begin
            if (auto_w_ff)
                act_w_ff <= full_w(seq_hsize_in);
            if (auto_h_ff)
                act_h_ff <= seq_vsize_in;
        end
    end

    assign win_x_out = act_x_ff;
    assign win_y_out = act_y_ff;
    assign win_w_out = act_w_ff;
    assign win_h_out = act_h_ff;

    ////////////////////////////////////////////////////////////////////
    // Speed divisor, refreshed on a slow command whose divisor lies from SPEED_MIN to SPEED_MAX
    logic [3:0] speed_ff;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            speed_ff <= SPEED_RST;
        else if (is_slow && arg_ff[1][3:0] >= SPEED_MIN &&
                 arg_ff[1][3:0] <= SPEED_MAX)
            speed_ff <= arg_ff[1][3:0];
    end
    assign speed_out = speed_ff;

    ////////////////////////////////////////////////////////////////////
    // Playback state machine
    dwpc_state_e state_ff, nxt_state;
    logic        step_req_ff, slow_req_ff;
    logic [1:0]  step_cnt_ff;
    logic        from_idle_ff;
    logic [4:0]  hold_ff;
    logic        slow_tick;

    // Playback commands queue a target while setup runs
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            step_req_ff <= 1'b0;
            slow_req_ff <= 1'b0;
        end else begin
            if (is_step)
                step_req_ff <= 1'b1;
            else if (state_ff == DWPC_STEP || state_ff == DWPC_FROZEN)
                step_req_ff <= 1'b0;
            if (is_slow)
                slow_req_ff <= 1'b1;
            else if (state_ff == DWPC_SLOW)
                slow_req_ff <= 1'b0;
        end
    end

    // Field counter: each slow picture stays 2 x speed fields
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            hold_ff <= FLD_HOLD_RST;
        else if (state_ff != DWPC_SLOW)
            hold_ff <= FLD_HOLD_RST;
        else if (vs_edge)
            hold_ff <= slow_tick ? FLD_HOLD_RST : hold_ff + 5'h01;
    end
    assign slow_tick = vs_edge &&
                       hold_ff == 5'({speed_ff, 1'b0} - 5'h01);

    // Pictures decoded since leaving quiescent; two before unblank
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            step_cnt_ff  <= 2'h0;
            from_idle_ff <= 1'b0;
        end else if (state_ff == DWPC_IDLE && is_step) begin
            step_cnt_ff  <= 2'h0;
            from_idle_ff <= 1'b1;
        end else if (pic_done_in && step_cnt_ff != STEP_FROM_IDLE) begin
            step_cnt_ff  <= step_cnt_ff + 2'h1;
        end else if (state_ff == DWPC_HELD) begin
            from_idle_ff <= 1'b0;
        end
    end

    // Next playback state; the unused code is never entered
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            DWPC_IDLE:
                if (is_step || is_slow)
                    nxt_state = DWPC_SETUP;
            DWPC_SETUP:
                nxt_state = DWPC_PLAY;
            DWPC_PLAY:
                if (step_req_ff && from_idle_ff)
                    nxt_state = pic_done_in ? DWPC_FROZEN : DWPC_PLAY;
                else if (step_req_ff)
                    nxt_state = DWPC_STEP;
                else if (slow_req_ff)
                    nxt_state = DWPC_SLOW;
            DWPC_STEP, DWPC_FROZEN:
                if (pic_done_in)
                    nxt_state = DWPC_HELD;
            DWPC_HELD:
                if (is_step)
                    nxt_state = DWPC_STEP;
                else if (is_slow)
                    nxt_state = DWPC_SLOW;
            DWPC_SLOW:
                if (is_step)
                    nxt_state = DWPC_STEP;
        endcase
    end

    // State register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            state_ff <= DWPC_IDLE;
        else
            state_ff <= nxt_state;
    end

    ////////////////////////////////////////////////////////////////////
    // Decode control outputs, registered
    // Go follows the state a clock late, so it is still up in the cycle
    // a picture finishes; the engine must not take that as a new request
    logic go_ff, post_ff, unblank_ff, sync_en_ff;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            go_ff      <= 1'b0;
            post_ff    <= 1'b0;
            unblank_ff <= 1'b0;
            sync_en_ff <= 1'b0;
        end else begin
            // Sync never paces stepping or slow decoding
            sync_en_ff <= state_ff == DWPC_PLAY && !step_req_ff &&
                          !slow_req_ff;
            unique case (state_ff)
                DWPC_PLAY:   go_ff <= from_idle_ff || av_sync_go_in ||
                                      !sync_en_ff;
                DWPC_STEP,
                DWPC_FROZEN: go_ff <= 1'b1;
                DWPC_SLOW:   go_ff <= slow_tick;
                default:     go_ff <= 1'b0;
            endcase
            post_ff <= pic_done_in && state_ff != DWPC_IDLE;
            if (state_ff == DWPC_IDLE)
                unblank_ff <= 1'b0;
            else if (step_cnt_ff == STEP_FROM_IDLE || !from_idle_ff)
                unblank_ff <= 1'b1;
        end
    end
    assign decode_go_out  = go_ff;
    assign post_pic_out   = post_ff;
    assign unblank_out    = unblank_ff;
    assign av_sync_en_out = sync_en_ff;
    assign state_out      = state_ff;

    ////////////////////////////////////////////////////////////////////
    // Read port: data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            rdata_out <= 16'h0000;
        else if (rd_in) begin
            unique case (addr_in)
                REG_CMD:    rdata_out <= cmd_ff;
                REG_ARG1:   rdata_out <= arg_ff[1];
                REG_ARG2:   rdata_out <= arg_ff[2];
                REG_ARG3:   rdata_out <= arg_ff[3];
                REG_ARG4:   rdata_out <= arg_ff[4];
                REG_STATUS: rdata_out <= {9'h000, unblank_ff, pend_ff,
                                          fmt60_ff, 1'b0, state_ff};
                REG_WIN_X:  rdata_out <= {1'b0, act_x_ff};
                REG_WIN_Y:  rdata_out <= {1'b0, act_y_ff};
                REG_WIN_W:  rdata_out <= {1'b0, act_w_ff};
                REG_WIN_H:  rdata_out <= {1'b0, act_h_ff};
                REG_SPEED:  rdata_out <= {12'h000, speed_ff};
                default:    rdata_out <= 16'h0000;
            endcase
        end else
            rdata_out <= 16'h0000;
    end

endmodule
`default_nettype wire

// *** hw/dwpc_pkg.sv ***
/*
 * Constants, command codes and playback states for the display window and
 * playback command handler.
 * Assumes a host that writes five command words and then pulses execute.
 */
package dwpc_pkg;
    // Register indices on the plain port
    localparam logic [3:0]  REG_CMD       = 4'h0;
    localparam logic [3:0]  REG_ARG1      = 4'h1;
    localparam logic [3:0]  REG_ARG2      = 4'h2;
    localparam logic [3:0]  REG_ARG3      = 4'h3;
    localparam logic [3:0]  REG_ARG4      = 4'h4;
    localparam logic [3:0]  REG_EXEC      = 4'h5;
    localparam logic [3:0]  REG_STATUS    = 4'h6;
    localparam logic [3:0]  REG_WIN_X     = 4'h7;
    localparam logic [3:0]  REG_WIN_Y     = 4'h8;
    localparam logic [3:0]  REG_WIN_W     = 4'h9;
    localparam logic [3:0]  REG_WIN_H     = 4'ha;
    localparam logic [3:0]  REG_SPEED     = 4'hb;
    // Command codes
    localparam logic [15:0] CMD_FORMAT    = 16'h0105;
    localparam logic [15:0] CMD_WINDOW    = 16'h0406;
    localparam logic [15:0] CMD_STEP      = 16'h000b;
    localparam logic [15:0] CMD_SLOW      = 16'h0109;
    // Format values
    localparam logic [2:0]  FMT_50HZ      = 3'h3;
    localparam logic [2:0]  FMT_60HZ      = 3'h4;
    // Speed limits and reset values
    localparam logic [3:0]  SPEED_MIN     = 4'h2;
    localparam logic [3:0]  SPEED_MAX     = 4'h8;
    localparam logic [3:0]  SPEED_RST     = 4'h2;
    localparam logic [14:0] WIN_ARG_RST   = 15'h0000;
    localparam logic [4:0]  FLD_HOLD_RST  = 5'h00;
    // Decoded picture count needed from quiescent before unblanking
    localparam logic [1:0]  STEP_FROM_IDLE = 2'h2;

    typedef enum logic [2:0] {
        DWPC_IDLE, DWPC_SETUP, DWPC_PLAY, DWPC_STEP,
        DWPC_FROZEN, DWPC_HELD, DWPC_SLOW
    } dwpc_state_e;
endpackage

// *** sim/dwpc_checker.sv ***
/*
 * Port-level assertions for the command handler.
 * Assumes a bind from the bench top and a single clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
module dwpc_checker
    import dwpc_pkg::*;
(
    // Watched ports
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        vsync_n_in,
    input  wire logic        pic_done_in,
    input  wire logic        decode_go_out,
    input  wire logic        post_pic_out,
    input  wire logic        av_sync_en_out,
    input  wire logic        field_60hz_out,
    input  wire logic [14:0] win_x_out,
    input  wire logic [3:0]  speed_out,
    input  wire logic [2:0]  state_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [15:0] cmd_ff;
    logic [15:0] arg_ff;
    logic        vs_ff;
    logic [3:0]  since_fall_ff;
    logic        exec;
    logic        spd_ok;
    ////////////////////////////////////////
    // Execute strobe and legal speed word
    assign exec   = wr_in && (addr_in == REG_EXEC);
    assign spd_ok = (arg_ff[15:4] == 12'h000) && (arg_ff[3:0] >= SPEED_MIN)
                    && (arg_ff[3:0] <= SPEED_MAX);
    // Shadow of command word and first argument
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_ff <= 16'h0000;
            arg_ff <= 16'h0000;
        end else if (wr_in && addr_in == REG_CMD) begin
            cmd_ff <= wdata_in;
        end else if (wr_in && addr_in == REG_ARG1) begin
            arg_ff <= wdata_in;
        end
    end
    // Age of the last field sync fall, saturating so it never wraps
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            vs_ff         <= 1'b1;
            since_fall_ff <= 4'hf;
        end else begin
            vs_ff <= vsync_n_in;
            if (vs_ff && !vsync_n_in) begin
                since_fall_ff <= 4'h0;
            end else if (since_fall_ff != 4'hf) begin
                since_fall_ff <= since_fall_ff + 4'h1;
            end
        end
    end
    ////////////////////////////////////////
    property p_fmt60;
        exec && cmd_ff == CMD_FORMAT && arg_ff == 16'h0004 |=> field_60hz_out;
    endproperty
    a_fmt60: assert property (p_fmt60) else $error("60 Hz not applied");
    property p_fmt50;
        exec && cmd_ff == CMD_FORMAT && arg_ff == 16'h0003 |=> !field_60hz_out;
    endproperty
    a_fmt50: assert property (p_fmt50) else $error("50 Hz not applied");
    property p_speed;
        exec && cmd_ff == CMD_SLOW && spd_ok |=> speed_out == arg_ff[3:0];
    endproperty
    a_speed: assert property (p_speed) else $error("divisor not taken");
    property p_speed_bad;
        exec && cmd_ff == CMD_SLOW && !spd_ok |=> $stable(speed_out);
    endproperty
    a_speed_bad: assert property (p_speed_bad) else $error("bad speed used");
    property p_slow_st;
        exec && cmd_ff == CMD_SLOW && spd_ok |-> ##[1:16] state_out == DWPC_SLOW;
    endproperty
    a_slow_st: assert property (p_slow_st) else $error("slow not entered");
    property p_win_vs;
        $changed(win_x_out) |-> since_fall_ff <= 4'h7;
    endproperty
    a_win_vs: assert property (p_win_vs) else $error("window moved off sync");
    property p_post;
        pic_done_in && state_out != DWPC_IDLE |=> post_pic_out;
    endproperty
    a_post: assert property (p_post) else $error("picture not posted");
    property p_held;
        (state_out == DWPC_STEP || state_out == DWPC_FROZEN) && pic_done_in
            |-> ##[1:4] state_out == DWPC_HELD;
    endproperty
    a_held: assert property (p_held) else $error("no hold after step");
    property p_slow_sync;
        state_out == DWPC_SLOW && $past(state_out) == DWPC_SLOW |-> !av_sync_en_out;
    endproperty
    a_slow_sync: assert property (p_slow_sync) else $error("sync in slow");
    property p_slow_go;
        state_out == DWPC_SLOW && decode_go_out |=> !decode_go_out;
    endproperty
    a_slow_go: assert property (p_slow_go) else $error("slow go too long");
    // Main scenarios reached
    c_slow: cover property (state_out == DWPC_SLOW);
    c_held: cover property (state_out == DWPC_HELD);
    c_win: cover property ($changed(win_x_out));
endmodule
`default_nettype wire

// *** sim/dwpc_engine_model.sv ***
/*
 * Decode engine stand-in: answers each decode request after DLY cycles.
 * Assumes one picture per request and a fixed sequence size.
 */
`timescale 1ns/10ps
`default_nettype none
module dwpc_engine_model #(
    parameter int          DLY   = 20,
    parameter logic [14:0] HSIZE = 15'h0160,
    parameter logic [14:0] VSIZE = 15'h00f0
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Handler side
    input  wire logic        decode_go_in,
    output logic             pic_done_out,
    output logic             seq_hdr_out,
    output logic      [14:0] hsize_out,
    output logic      [14:0] vsize_out
);
    logic busy;
    logic sent;
    int   cnt;
    assign hsize_out = HSIZE;
    assign vsize_out = VSIZE;
    // One header after reset, then pictures on request
    // No coded buffer here, so nothing can overflow when slowed
    // A request seen as a picture finishes is stale: the handler's
    // registered go lags its state by one clock
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy <= 1'b0;
            sent <= 1'b0;
            cnt <= 0;
            pic_done_out <= 1'b0;
            seq_hdr_out <= 1'b0;
        end else begin
            seq_hdr_out <= !sent;
            sent <= 1'b1;
            pic_done_out <= 1'b0;
            if (!busy && decode_go_in && !pic_done_out) begin
                busy <= 1'b1;
                cnt <= 0;
            end else if (busy && cnt == DLY - 1) begin
                busy <= 1'b0;
                pic_done_out <= 1'b1;
            end else if (busy) begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/tb_dwpc_top.sv ***
/*
 * Directed bench for the window and playback command handler.
 * Assumes the engine model answers decode requests after a fixed delay.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_dwpc_top;
    import dwpc_pkg::*;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [3:0]  addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic        vsync_n_in = 1'b1;
    logic        av_go = 1'b0;
    logic [15:0] rdata_out;
    logic        pdone, shdr, go, post, unblank, f60, sync_en;
    logic [14:0] hsz, vsz, wx, wy, ww, wh;
    logic [3:0]  speed;
    logic [2:0]  state;
    int          error_cnt = 0;
    int          total_checks = 0;
    int          post_cnt = 0;
    int          go_cnt = 0;
    ////////////////////////////////////////
    dwpc_top dwpc_top_i (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .vsync_n_in(vsync_n_in), .pic_done_in(pdone),
        .seq_hdr_in(shdr), .seq_hsize_in(hsz), .seq_vsize_in(vsz),
        .av_sync_go_in(av_go), .decode_go_out(go), .post_pic_out(post),
        .unblank_out(unblank), .av_sync_en_out(sync_en), .field_60hz_out(f60),
        .win_x_out(wx), .win_y_out(wy), .win_w_out(ww), .win_h_out(wh),
        .speed_out(speed), .state_out(state));
    dwpc_engine_model dwpc_engine_model_i (.clk_in(clk_in), .rst_in(rst_in),
        .decode_go_in(go), .pic_done_out(pdone), .seq_hdr_out(shdr),
        .hsize_out(hsz), .vsize_out(vsz));
    // Clock and event counters
    always #2 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (post === 1'b1) post_cnt <= post_cnt + 1;
        if (go === 1'b1 && state === DWPC_SLOW) go_cnt <= go_cnt + 1;
    end
    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Five words then the execute strobe, write strobe held across all six
    task automatic do_cmd(input logic [15:0] c, a1, a2, a3, a4);
        logic [15:0] w [6];
        w = '{c, a1, a2, a3, a4, 16'h0000};
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_in);
            addr_in <= i[3:0];
            wdata_in <= w[i];
            wr_in <= 1'b1;
        end
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input string name, input logic [3:0] a,
                          input logic [15:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk(name, exp, rdata_out);
    endtask
    // Bounded wait; a miss is counted and ends the run
    task automatic wait_state(input logic [2:0] s, input int lim);
        int n;
        n = 0;
        while (state !== s && n < lim) begin
            @(posedge clk_in);
            #1 n++;
        end
        chk("state", {13'h0, s}, {13'h0, state});
        if (state !== s) print_verdict();
    endtask
    task automatic vs_pulse();
        @(posedge clk_in);
        vsync_n_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        vsync_n_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        #1;
    endtask
    ////////////////////////////////////////
    task automatic t_format();
        chk("fmt60", 16'h1, {15'h0, f60});
        do_cmd(CMD_FORMAT, 16'h0003, 16'h0, 16'h0, 16'h0);
        chk("fmt60", 16'h0, {15'h0, f60});
        do_cmd(CMD_FORMAT, 16'h0007, 16'h0, 16'h0, 16'h0);
        chk("fmt60", 16'h0, {15'h0, f60});
        do_cmd(CMD_FORMAT, 16'h0004, 16'h0, 16'h0, 16'h0);
        chk("fmt60", 16'h1, {15'h0, f60});
        rd_chk("status", REG_STATUS, 16'h0010);
        rd_chk("unmapped", 4'hf, 16'h0000);
    endtask
    // Window kept inside the 704 by 240 doubled picture
    task automatic t_window();
        do_cmd(CMD_WINDOW, 16'h0010, 16'h0008, 16'h0280, 16'h00c8);
        chk("win_x", 16'h0, {1'b0, wx});
        rd_chk("status", REG_STATUS, 16'h0030);
        vs_pulse();
        chk("win_x", 16'h0010, {1'b0, wx});
        chk("win_y", 16'h0008, {1'b0, wy});
        chk("win_h", 16'h00c8, {1'b0, wh});
        rd_chk("win_w", REG_WIN_W, 16'h0280);
        do_cmd(CMD_WINDOW, 16'h0, 16'h0, 16'h0, 16'h0);
        chk("win_w", 16'h0280, {1'b0, ww});
        vs_pulse();
        chk("win_w", 16'h02c0, {1'b0, ww});
        chk("win_h", 16'h00f0, {1'b0, wh});
    endtask
    task automatic t_step();
        post_cnt = 0;
        do_cmd(CMD_STEP, 16'h0, 16'h0, 16'h0, 16'h0);
        wait_state(DWPC_HELD, 400);
        // Post lands with the state and unblank one cycle after it
        repeat (2) @(posedge clk_in);
        #1;
        chk("posted", 16'h2, post_cnt[15:0]);
        chk("unblank", 16'h1, {15'h0, unblank});
        rd_chk("status", REG_STATUS, 16'h0055);
        post_cnt = 0;
        do_cmd(CMD_STEP, 16'h0, 16'h0, 16'h0, 16'h0);
        chk("state", {13'h0, DWPC_STEP}, {13'h0, state});
        wait_state(DWPC_HELD, 200);
        repeat (2) @(posedge clk_in);
        #1;
        chk("posted", 16'h1, post_cnt[15:0]);
    endtask
    task automatic t_slow();
        logic [15:0] arg [4];
        logic [15:0] exp [4];
        arg = '{16'h0009, 16'h0008, 16'h0001, 16'h0002};
        exp = '{16'h0004, 16'h0008, 16'h0008, 16'h0002};
        // Sync allowed throughout; it must not pace slow decoding
        @(posedge clk_in);
        av_go <= 1'b1;
        do_cmd(CMD_SLOW, 16'h0004, 16'h0, 16'h0, 16'h0);
        wait_state(DWPC_SLOW, 50);
        chk("speed", 16'h4, {12'h0, speed});
        for (int i = 0; i < 4; i++) begin
            do_cmd(CMD_SLOW, arg[i], 16'h0, 16'h0, 16'h0);
            chk("speed", exp[i], {12'h0, speed});
        end
        rd_chk("speed", REG_SPEED, 16'h0002);
        go_cnt = 0;
        repeat (8) vs_pulse();
        chk("pictures", 16'h2, go_cnt[15:0]);
        chk("sync_en", 16'h0, {15'h0, sync_en});
    endtask
    // Reset, scenarios, verdict
    initial begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        t_format();
        t_window();
        t_step();
        t_slow();
        print_verdict();
    end
endmodule
bind dwpc_top dwpc_checker dwpc_checker_i (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .vsync_n_in(vsync_n_in), .pic_done_in(pic_done_in),
    .decode_go_out(decode_go_out), .post_pic_out(post_pic_out),
    .av_sync_en_out(av_sync_en_out), .field_60hz_out(field_60hz_out),
    .win_x_out(win_x_out), .speed_out(speed_out), .state_out(state_out));
`default_nettype wire
